// file: rtl/flash_status_config_regs.sv
/*
  status and configuration register bank of a nor flash program/erase
  engine: sticky error flags, suspend and bank-write state, config.
  assumes one-cycle command and engine report pulses, and block lock
  and supply inputs synchronous to clk.
*/
// How it works
// R1: erase pulses exhausted, not erased sets erase fail
// R2: blank check mismatch sets erase fail
// R3: erase fail sticky; new erase then fails
// R4: program pulses exhausted, unverified sets program fail
// R5: one-over-zero fails only at high supply
// R6: program fail sticky; new program then fails
// R7: supply sampled only at operation start
// R8: low supply sets sticky supply error, refuses
// R9: suspend sets paused flag within latency
// R10: resume clears paused flag, program continues
// R11: host reads paused flag only when ready
// R12: locked block target sets flag, aborts
// R13: locked flag sticky; program/erase then fail
// R14: bank write zero if addressed bank busy
// R15: factory mode bank write shows word readiness
// R16: host reads bank write only while busy
// R17: config loaded only by set-config command
// R18: reset selects synchronous reads, bit zero
// R19: ready flag low while any bank active
// R20: errors device-set, cleared only by clear/reset
// R21: eight-bit status word, ready msb, bank lsb
`timescale 1ns/100ps
module flash_status_config_regs #(
  parameter int unsigned BANK_W = 4,
  parameter int unsigned SUSPEND_CYCLES =
    flash_status_pkg::SUSPEND_LATENCY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire flash_status_pkg::host_cmd_t cmd,
  input wire logic [BANK_W-1:0] read_bank,
  input wire logic target_locked,
  input wire logic program_supply_lockout,
  input wire logic program_supply_high,
  input wire flash_status_pkg::engine_report_t report,
  input wire logic buffered_factory_program,
  input wire logic factory_word_ready,
  output logic op_start,
  output logic op_abort,
  output logic op_suspend,
  output logic op_resume,
  output logic [7:0] flash_status_reg,
  output logic [15:0] bus_access_config_reg,
  output logic read_mode_select
);

  import flash_status_pkg::*;

  // ----------------
  // command decode
  // ----------------
  wire logic is_program = cmd_valid && (cmd.kind == CMD_PROGRAM);
  wire logic is_erase = cmd_valid && (cmd.kind == CMD_ERASE);
  wire logic is_blank = cmd_valid && (cmd.kind == CMD_BLANK_CHECK);
  wire logic is_suspend = cmd_valid && (cmd.kind == CMD_SUSPEND);
  wire logic is_resume = cmd_valid && (cmd.kind == CMD_RESUME);
  wire logic is_clear = cmd_valid && (cmd.kind == CMD_CLEAR_STATUS);
  wire logic is_set_cfg = cmd_valid && (cmd.kind == CMD_SET_CONFIG);

  // ----------------
  // controller state
  // ----------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROGRAM,
    ST_ERASE,
    ST_PAUSED
  } ctrl_state_t;

  ctrl_state_t state_reg; // what the engine is doing
  ctrl_state_t state_next; // state after this cycle
  logic [BANK_W-1:0] busy_bank_reg; // bank owning the running op
  logic blank_op_reg; // erase slot is running a blank check
  logic supply_high_reg; // supply level taken at op start

  // sticky error flags, plus the paused flag
  logic erase_fail_flag;
  logic program_fail_flag;
  logic supply_error_flag;
  logic locked_block_flag;
  logic program_paused_flag;

  // suspend window helpers
  logic susp_running;
  logic susp_expired;

  wire logic idle = (state_reg == ST_IDLE);
  wire logic paused = (state_reg == ST_PAUSED);
  wire logic write_cmd = is_program || is_erase || is_blank;

  // ----------------
  // start-time checks
  // ----------------
  // supply is looked at only here, never while the op runs
  wire logic supply_low = write_cmd && idle &&
                          program_supply_lockout; // R7
  // locked target aborts program or erase; blank check only reads
  wire logic lock_hit = (is_program || is_erase) && idle &&
                        target_locked; // R12
  // a pending fail of the same kind, or a supply or lock error, makes a new write appear to fail
  wire logic prior_erase_err = erase_fail_flag ||
                               supply_error_flag ||
                               locked_block_flag; // R3 R13
  wire logic prior_prog_err = program_fail_flag ||
                              supply_error_flag ||
                              locked_block_flag; // R6 R13
  wire logic erase_refused = (is_erase || is_blank) &&
                             prior_erase_err; // R3
  wire logic prog_refused = is_program && prior_prog_err; // R6
  wire logic refused = supply_low || lock_hit ||
                       erase_refused || prog_refused; // R8
  wire logic accepted = write_cmd && idle && !refused;

  // ----------------
  // engine results
  // ----------------
  wire logic running_erase = (state_reg == ST_ERASE);
  wire logic running_prog = (state_reg == ST_PROGRAM);
  // erase fails on exhausted pulses left unverified, blank check on any non-ffff word
  wire logic erase_err = report.op_done && running_erase &&
                         ((!blank_op_reg && report.pulses_exhausted &&
                           report.verify_failed) || // R1
                          (blank_op_reg &&
                           report.blank_mismatch)); // R2
  wire logic prog_verify_err = report.op_done && running_prog &&
                               report.pulses_exhausted &&
                               report.verify_failed; // R4
  // a one over a programmed zero only shows at high supply
  wire logic prog_overwrite_err = report.op_done && running_prog &&
                                  report.one_over_zero &&
                                  supply_high_reg; // R5

  // ----------------
  // sticky flags: device sets, clear-status or reset clears
  // ----------------
  sticky_flag u_erase_fail (
    .clk(clk),
    .rst(rst),
    .set_pulse(erase_err || erase_refused), // R20
    .clear_pulse(is_clear),
    .flag(erase_fail_flag)
  );

  sticky_flag u_program_fail (
    .clk(clk),
    .rst(rst),
    .set_pulse(prog_verify_err || prog_overwrite_err ||
               prog_refused), // R20
    .clear_pulse(is_clear),
    .flag(program_fail_flag)
  );

  sticky_flag u_supply_error (
    .clk(clk),
    .rst(rst),
    .set_pulse(supply_low), // R8
    .clear_pulse(is_clear),
    .flag(supply_error_flag)
  );

  sticky_flag u_locked_block (
    .clk(clk),
    .rst(rst),
    .set_pulse(lock_hit), // R12
    .clear_pulse(is_clear),
    .flag(locked_block_flag)
  );

  // ----------------
  // suspend latency window
  // ----------------
  suspend_timer #(
    .COUNT(SUSPEND_CYCLES)
  ) u_suspend_timer (
    .clk(clk),
    .rst(rst),
    .start(is_suspend && running_prog && !susp_running),
    .cancel(report.op_done || report.paused || idle),
    .running(susp_running),
    .expired(susp_expired)
  );

  // engine pauses on its own report, or is forced at the window end;
  // expired rises as running falls, so it carries no running gate
  wire logic enter_pause = running_prog &&
                           ((susp_running && report.paused) ||
                            susp_expired) && !report.op_done; // R9

  // ----------------
  // next-state logic
  // ----------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (accepted && is_program) begin
          state_next = ST_PROGRAM;
        end else if (accepted) begin
          state_next = ST_ERASE;
        end
      end
      ST_PROGRAM: begin
        if (report.op_done) begin
          state_next = ST_IDLE; // finished before suspending
        end else if (enter_pause) begin
          state_next = ST_PAUSED; // R9
        end
      end
      ST_ERASE: begin
        if (report.op_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_PAUSED: begin
        if (is_resume) begin
          state_next = ST_PROGRAM; // R10
        end
      end
    endcase
  end

  // ----------------
  // state, bank and supply capture
  // ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      busy_bank_reg <= '0;
      blank_op_reg <= 1'b0;
      supply_high_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (accepted) begin
        busy_bank_reg <= cmd.bank[BANK_W-1:0];
        blank_op_reg <= is_blank;
        supply_high_reg <= program_supply_high; // R7
      end
    end
  end

  // paused flag follows the controller state, device-owned
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      program_paused_flag <= 1'b0;
    end else if (is_resume && paused) begin
      program_paused_flag <= 1'b0; // R10
    end else if (enter_pause) begin
      program_paused_flag <= 1'b1; // R9
    end
  end

  // ----------------
  // engine command outputs
  // ----------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_start <= 1'b0;
      op_abort <= 1'b0;
      op_suspend <= 1'b0;
      op_resume <= 1'b0;
    end else begin
      op_start <= accepted;
      op_abort <= write_cmd && idle && refused; // R12
      op_suspend <= enter_pause;
      op_resume <= is_resume && paused; // R10
    end
  end

  // ----------------
  // status word assembly
  // ----------------
  // a paused engine counts as inactive so the host may read it
  wire logic ctrl_ready = idle || paused; // R19
  // bank write: 0 on own bank or when ready, 1 elsewhere while busy; in factory mode readiness
  wire logic bank_write = buffered_factory_program ?
                          !factory_word_ready : // R15
                          (!ctrl_ready &&
                           (read_bank != busy_bank_reg)); // R14
  logic [7:0] status_next;
  always_comb begin
    status_next = 8'h00;
    status_next[CONTROLLER_READY_BIT] = ctrl_ready; // R21
    status_next[ERASE_FAIL_BIT] = erase_fail_flag;
    status_next[PROGRAM_FAIL_BIT] = program_fail_flag;
    status_next[SUPPLY_ERROR_BIT] = supply_error_flag;
    status_next[PROGRAM_PAUSED_BIT] = program_paused_flag;
    status_next[LOCKED_BLOCK_BIT] = locked_block_flag;
    status_next[BANK_WRITE_BIT] = bank_write; // R21
  end

  // registered status so the output comes straight from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_status_reg <= 8'h80;
    end else begin
      flash_status_reg <= status_next;
    end
  end

  // ----------------
  // configuration register
  // ----------------
  // only the set-config command writes it; no other path exists
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_access_config_reg <= CONFIG_RESET; // R18
      read_mode_select <= 1'b0; // R18
    end else if (is_set_cfg) begin
      bus_access_config_reg <= cmd.data & CONFIG_WRITE_MASK; // R17
      read_mode_select <= cmd.data[READ_MODE_SELECT_BIT]; // R17
    end
  end

endmodule

// file: rtl/flash_status_pkg.sv
/*
  package for the flash status and configuration register bank:
  status bit positions, command codes, reset values, timing counts.
  assumes a 200 MHz single clock domain.
*/
package flash_status_pkg;

  // ----------------
  // status word bit positions
  // ----------------
  localparam int unsigned CONTROLLER_READY_BIT = 7;
  localparam int unsigned ERASE_SUSPEND_BIT = 6;
  localparam int unsigned ERASE_FAIL_BIT = 5;
  localparam int unsigned PROGRAM_FAIL_BIT = 4;
  localparam int unsigned SUPPLY_ERROR_BIT = 3;
  localparam int unsigned PROGRAM_PAUSED_BIT = 2;
  localparam int unsigned LOCKED_BLOCK_BIT = 1;
  localparam int unsigned BANK_WRITE_BIT = 0;

  // ----------------
  // configuration register fields and reset value
  // ----------------
  localparam int unsigned READ_MODE_SELECT_BIT = 15;
  localparam int unsigned SPARE_CFG_BIT = 14;
  // read mode 0 (synchronous) after reset; other fields left at zero
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  // spare bit always reads zero
  localparam logic [15:0] CONFIG_WRITE_MASK = 16'hbfff;

  // ----------------
  // blank-check expected value
  // ----------------
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ----------------
  // suspend latency: chosen window in ns and in clock cycles
  // ----------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SUSPEND_LATENCY_NS = 5000;
  localparam int unsigned SUSPEND_LATENCY_CYCLES =
    SUSPEND_LATENCY_NS / CLK_PERIOD_NS;

  // ----------------
  // host command kinds
  // ----------------
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_PROGRAM,
    CMD_ERASE,
    CMD_BLANK_CHECK,
    CMD_SUSPEND,
    CMD_RESUME,
    CMD_CLEAR_STATUS,
    CMD_SET_CONFIG
  } cmd_kind_t;

  // command as issued by the host through the command interface
  typedef struct packed {
    cmd_kind_t kind;
    logic [3:0] bank;
    logic [15:0] data;
  } host_cmd_t;

  // result reports from the program/erase array engine
  typedef struct packed {
    logic op_done;
    logic pulses_exhausted;
    logic verify_failed;
    logic one_over_zero;
    logic blank_mismatch;
    logic paused;
  } engine_report_t;

endpackage

// file: rtl/sticky_flag.sv
/*
  one sticky error flag: set by the device, cleared by clear-status.
  assumes set and clear are one-cycle pulses in the clk domain.
*/
`timescale 1ns/100ps
module sticky_flag (
  input wire logic clk,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);

  // ----------------
  // flag storage
  // ----------------
  // set wins over clear so a late event is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clear_pulse) begin
      flag <= 1'b0;
    end
  end

endmodule

// file: rtl/suspend_timer.sv
/*
  counts the suspend latency window after a suspend request.
  assumes start is a one-cycle pulse; expired pulses once at the end.
*/
`timescale 1ns/100ps
module suspend_timer #(
  parameter int unsigned COUNT = 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic cancel,
  output logic running,
  output logic expired
);

  // ----------------
  // countdown
  // ----------------
  localparam int unsigned W = $clog2(COUNT + 1);
  logic [W-1:0] count_reg; // cycles still to wait

  // counter reloads on start, stops on cancel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (cancel) begin
        running <= 1'b0;
      end else if (start) begin
        count_reg <= W'(COUNT - 1);
        running <= 1'b1;
      end else if (running) begin
        if (count_reg == '0) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule

// file: verification/array_engine_model.sv
/*
  behavioural program/erase engine behind the register bank.
  assumes op_start, op_suspend and op_resume are one-cycle pulses.
*/
`timescale 1ns/100ps
module array_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_start,
  input wire logic op_suspend,
  input wire logic op_resume,
  input wire flash_status_pkg::engine_report_t plan,
  input wire logic [7:0] op_cycles,
  output flash_status_pkg::engine_report_t report
);
  import flash_status_pkg::*;
  logic [7:0] left_reg; // cycles until the result, zero when idle
  logic hold_reg; // frozen while paused
  // one count per cycle, except on a start or while frozen
  wire logic step = !op_start && (left_reg != 8'h00) && !hold_reg;
  // counts down, then reports the planned outcome for one cycle;
  // supply is never looked at mid-operation; paused is never reported
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_reg <= 8'h00;
      hold_reg <= 1'b0;
      report <= '0;
    end else begin
      if (op_start) begin
        left_reg <= op_cycles;
      end else if (step) begin
        left_reg <= left_reg - 8'h01;
      end
      report <= (step && left_reg == 8'h01) ?
                {1'b1, plan[4:1], 1'b0} : '0;
      hold_reg <= (hold_reg || op_suspend) && !op_resume;
    end
  end
endmodule

// file: verification/flash_status_config_regs_properties.sv
/*
  checker for the flash status and configuration register bank.
  assumes only the bank's ports; bound in at the foot of this file.
*/
`timescale 1ns/100ps
module flash_status_config_regs_properties #(
  parameter int unsigned BANK_W = 4,
  parameter int unsigned SUSPEND_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire flash_status_pkg::host_cmd_t cmd,
  input wire logic [BANK_W-1:0] read_bank,
  input wire logic target_locked,
  input wire logic program_supply_lockout,
  input wire logic program_supply_high,
  input wire flash_status_pkg::engine_report_t report,
  input wire logic buffered_factory_program,
  input wire logic factory_word_ready,
  input wire logic op_start,
  input wire logic op_abort,
  input wire logic op_suspend,
  input wire logic op_resume,
  input wire logic [7:0] flash_status_reg,
  input wire logic [15:0] bus_access_config_reg,
  input wire logic read_mode_select
);
  import flash_status_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------
  // decode of commands taken while idle
  // ----------------
  // op_start marks the cycle where status still shows the old ready
  wire idle_cmd = cmd_valid & flash_status_reg[7] & ~flash_status_reg[2]
    & ~op_start;
  wire write_cmd = idle_cmd & (cmd.kind inside {CMD_PROGRAM, CMD_ERASE,
    CMD_BLANK_CHECK});
  // blank check is not blocked by a locked block
  wire lock_hit = idle_cmd & target_locked
    & (cmd.kind inside {CMD_PROGRAM, CMD_ERASE});
  wire clear_cmd = cmd_valid & (cmd.kind == CMD_CLEAR_STATUS);
  wire config_cmd = cmd_valid & (cmd.kind == CMD_SET_CONFIG);
  wire [3:0] errors = {flash_status_reg[5:3], flash_status_reg[1]};
  // kind and supply level of the operation in flight
  cmd_kind_t pend_kind;
  cmd_kind_t op_kind;
  logic pend_high;
  logic op_high;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_kind <= CMD_NONE;
      op_kind <= CMD_NONE;
      pend_high <= 1'b0;
      op_high <= 1'b0;
    end else begin
      if (cmd_valid) begin
        pend_kind <= cmd.kind;
        pend_high <= program_supply_high;
      end
      if (op_start) begin
        op_kind <= pend_kind;
        op_high <= pend_high;
      end
    end
  end

  // ----------------
  // assertions
  // ----------------
  a_ready_low_busy: assert property (
    op_start |=> !flash_status_reg[7]) else $error("ready during op");
  a_refused_write_aborts: assert property (
    write_cmd && (program_supply_lockout || lock_hit) |=> op_abort
    && !op_start) else $error("refused write not aborted");
  a_lock_flag_set: assert property (
    lock_hit |-> ##2 flash_status_reg[1]) else $error("lock flag low");
  a_supply_flag_set: assert property (
    write_cmd && program_supply_lockout |-> ##2 flash_status_reg[3])
    else $error("supply flag low");
  a_errors_clear_only: assert property (
    |($past(errors) & ~errors) |-> $past(clear_cmd, 2))
    else $error("error flag fell without clear");
  a_erase_fail_report: assert property (
    report.op_done && (op_kind == CMD_ERASE && report.pulses_exhausted
    && report.verify_failed || op_kind == CMD_BLANK_CHECK
    && report.blank_mismatch) |-> ##2 flash_status_reg[5])
    else $error("erase fail flag low");
  a_program_fail_report: assert property (
    report.op_done && op_kind == CMD_PROGRAM && (report.pulses_exhausted
    && report.verify_failed || report.one_over_zero && op_high)
    |-> ##2 flash_status_reg[4]) else $error("program fail flag low");
  a_resume_clears: assert property (
    op_resume |=> !flash_status_reg[2]) else $error("paused after resume");
  a_suspend_pauses: assert property (
    op_suspend |=> flash_status_reg[2]) else $error("not paused");
  a_config_by_command: assert property (
    !$stable(bus_access_config_reg) |-> $past(config_cmd)
    || $past(config_cmd, 2)) else $error("config changed by itself");
  a_mode_follows_config: assert property (
    $rose(bus_access_config_reg[15]) |-> ##[0:1] read_mode_select)
    else $error("read mode not selected");
endmodule

bind flash_status_config_regs flash_status_config_regs_properties #(
  .BANK_W(BANK_W), .SUSPEND_CYCLES(SUSPEND_CYCLES)
) flash_status_config_regs_properties_i (
  .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .read_bank(read_bank), .target_locked(target_locked),
  .program_supply_lockout(program_supply_lockout),
  .program_supply_high(program_supply_high), .report(report),
  .buffered_factory_program(buffered_factory_program),
  .factory_word_ready(factory_word_ready), .op_start(op_start),
  .op_abort(op_abort), .op_suspend(op_suspend), .op_resume(op_resume),
  .flash_status_reg(flash_status_reg),
  .bus_access_config_reg(bus_access_config_reg),
  .read_mode_select(read_mode_select)
);

// file: verification/testbench.sv
/*
  self-checking bench for the flash status and configuration bank.
  assumes the engine model answers every started operation.
*/
`timescale 1ns/100ps
module testbench;
  import flash_status_pkg::*;
  localparam int unsigned SUSP = 4; // short suspend latency for sims
  typedef struct packed {
    logic sel;
    logic [15:0] exp;
    logic [7:0] mask;
  } note_t;
  logic clk, rst, cmd_valid, target_locked, program_supply_lockout, look;
  logic program_supply_high, buffered_factory_program, factory_word_ready;
  logic op_start, op_abort, op_suspend, op_resume, read_mode_select;
  logic [3:0] read_bank;
  logic [7:0] flash_status_reg, op_cycles, e;
  logic [15:0] bus_access_config_reg, d;
  host_cmd_t cmd;
  engine_report_t report, plan;
  int mismatches, compares, cycles;
  note_t notes[$];
  cmd_kind_t kinds [5] = '{CMD_PROGRAM, CMD_PROGRAM, CMD_PROGRAM,
    CMD_ERASE, CMD_BLANK_CHECK};
  logic [5:0] plans [5] = '{6'h18, 6'h04, 6'h04, 6'h18, 6'h02};
  logic [7:0] fails [5] = '{8'h10, 8'h10, 8'h00, 8'h20, 8'h20};
  logic [4:0] highs = 5'h03;

  flash_status_config_regs #(.BANK_W(4), .SUSPEND_CYCLES(SUSP))
  flash_status_config_regs_i (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .read_bank(read_bank), .target_locked(target_locked),
    .program_supply_lockout(program_supply_lockout),
    .program_supply_high(program_supply_high), .report(report),
    .buffered_factory_program(buffered_factory_program),
    .factory_word_ready(factory_word_ready), .op_start(op_start),
    .op_abort(op_abort), .op_suspend(op_suspend), .op_resume(op_resume),
    .flash_status_reg(flash_status_reg),
    .bus_access_config_reg(bus_access_config_reg),
    .read_mode_select(read_mode_select));
  array_engine_model array_engine_model_i (
    .clk(clk), .rst(rst), .op_start(op_start), .op_suspend(op_suspend),
    .op_resume(op_resume), .plan(plan), .op_cycles(op_cycles),
    .report(report));

  // ----------------
  // clock, watchdog and checking
  // ----------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic compare_status(logic [7:0] x, logic [7:0] m);
    compares++;
    if ((flash_status_reg & m) !== x) begin
      mismatches++;
      $display("unexpected status %h seen %h", x, flash_status_reg & m);
    end
  endtask
  task automatic compare_config(logic [15:0] x);
    compares++;
    if (bus_access_config_reg !== x || read_mode_select !== x[15]) begin
      mismatches++;
      $display("unexpected config %h seen %h", x, bus_access_config_reg);
    end
  endtask
  // the run is a few hundred cycles; a hang trips this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      mismatches++;
      complete_run();
    end
  end
  // takes the oldest note mid-cycle, where the flopped result is settled
  always @(negedge clk) begin
    if (look) begin
      if (notes[0].sel) compare_config(notes[0].exp);
      else compare_status(notes[0].exp[7:0], notes[0].mask);
      void'(notes.pop_front());
    end
  end

  // ----------------
  // driver tasks
  // ----------------
  task automatic send(cmd_kind_t k, logic [3:0] b, logic [15:0] v);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{kind: k, bank: b, data: v};
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  // status settles two edges after its cause
  task automatic note(logic s, logic [15:0] x, logic [7:0] m);
    notes.push_back('{sel: s, exp: x, mask: m});
    repeat (2) @(posedge clk);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask
  task automatic wait_for(int i, logic v, int limit);
    for (int n = 0; n < limit; n++) begin
      @(negedge clk);
      if (flash_status_reg[i] === v) break;
    end
    @(posedge clk);
  endtask
  task automatic finish_op;
    repeat (2) @(posedge clk);
    wait_for(7, 1'b1, 300);
  endtask

  // ----------------
  // scenarios
  // ----------------
  initial begin
    rst = 1'b1; cmd_valid = 1'b0; cmd = '0; read_bank = 4'h3;
    target_locked = 1'b0; program_supply_lockout = 1'b0; look = 1'b0;
    program_supply_high = 1'b0; buffered_factory_program = 1'b0;
    factory_word_ready = 1'b0; plan = '0; op_cycles = 8'h28;
    mismatches = 0; compares = 0; cycles = 0;
    void'($urandom(32'h58c4a4f4));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    note(0, 16'h0080, 8'hff);
    note(1, 16'h0000, 8'h00);
    for (int i = 0; i < 2; i++) begin
      d = 16'($urandom());
      d[15] = (i == 0);
      send(CMD_SET_CONFIG, 4'h0, d);
      note(1, d & CONFIG_WRITE_MASK, 8'h00);
    end
    send(CMD_PROGRAM, 4'h5, 16'h1234);
    note(0, 16'h0001, 8'h81);
    read_bank <= 4'h5;
    note(0, 16'h0000, 8'h81);
    finish_op();
    note(0, 16'h0080, 8'hff);
    note(1, d & CONFIG_WRITE_MASK, 8'h00);
    for (int i = 0; i < 5; i++) begin
      plan <= engine_report_t'(plans[i]);
      program_supply_high <= highs[i];
      op_cycles <= 8'($urandom_range(1, 12));
      send(kinds[i], 4'h1, 16'($urandom()));
      finish_op();
      note(0, {8'h00, fails[i] | 8'h80}, 8'hff);
      if (fails[i] != 8'h00) begin
        send(kinds[i], 4'h1, 16'h0000);
        note(0, {8'h00, fails[i] | 8'h80}, 8'hff);
      end
      send(CMD_CLEAR_STATUS, 4'h0, 16'h0000);
      note(0, 16'h0080, 8'hff);
    end
    plan <= '0;
    for (int i = 0; i < 4; i++) begin
      program_supply_lockout <= (i < 3);
      target_locked <= (i == 3);
      e = (i == 3) ? 8'h82 : 8'h88;
      send((i == 3) ? CMD_ERASE : cmd_kind_t'(i + 1), 4'h2, 16'h0000);
      note(0, {8'h00, e}, 8'hff);
      program_supply_lockout <= 1'b0;
      target_locked <= 1'b0;
      send(CMD_PROGRAM, 4'h2, 16'h0000);
      note(0, {8'h00, e | 8'h10}, 8'hff);
      send(CMD_CLEAR_STATUS, 4'h0, 16'h0000);
      note(0, 16'h0080, 8'hff);
    end
    op_cycles <= 8'h1e;
    send(CMD_PROGRAM, 4'h4, 16'h0000);
    program_supply_lockout <= 1'b1;
    finish_op();
    program_supply_lockout <= 1'b0;
    note(0, 16'h0080, 8'hff);
    op_cycles <= 8'hc8;
    send(CMD_PROGRAM, 4'h6, 16'h0000);
    @(posedge clk);
    send(CMD_SUSPEND, 4'h6, 16'h0000);
    wait_for(2, 1'b1, SUSP + 8);
    note(0, 16'h0084, 8'h84);
    send(CMD_RESUME, 4'h6, 16'h0000);
    note(0, 16'h0000, 8'h84);
    buffered_factory_program <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d[0] = 1'($urandom());
      factory_word_ready <= d[0];
      note(0, {15'h0000, ~d[0]}, 8'h81);
    end
    buffered_factory_program <= 1'b0;
    finish_op();
    note(0, 16'h0080, 8'hff);
    complete_run();
  end
endmodule
